// ===== eimo_pkg.sv
// constants of the event interrupt mask block: register indices, field positions, resets
// assumes a 32-bit apb slave where each register index maps to one aligned word

package eimo_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_EVENT_MASK   = 16'he50b;
    localparam logic [15:0] IDX_PHASE_SOURCE = 16'he600;
    localparam logic [15:0] IDX_MAIN_FLAGS   = 16'he502;

    // ----------------------------------------------------------------
    // event bit positions, shared by mask and main flags
    // ----------------------------------------------------------------
    localparam int BIT_NOLOAD_ACTRE   = 0;
    localparam int BIT_NOLOAD_APPAR   = 2;
    localparam int BIT_VOLT_MISS      = 3;
    localparam int BIT_CURR_MISS      = 6;
    localparam int BIT_VOLT_CROSS     = 9;
    localparam int BIT_CURR_CROSS     = 12;
    localparam int BIT_RESET_DONE     = 15;
    localparam int BIT_DIP            = 16;
    localparam int BIT_HIGH_CURR      = 17;
    localparam int BIT_HIGH_VOLT      = 18;
    localparam int BIT_PHASE_ORDER    = 19;
    localparam int BIT_CURR_PEAK      = 23;
    localparam int BIT_VOLT_PEAK      = 24;

    // ----------------------------------------------------------------
    // phase source field positions
    // ----------------------------------------------------------------
    localparam int PH_HIGH_CURR = 3;
    localparam int PH_HIGH_VOLT = 9;
    localparam int PH_DIP       = 12;

    // ----------------------------------------------------------------
    // reset values and implemented bits
    // ----------------------------------------------------------------
    localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
    localparam logic [31:0] MASK_WRITABLE  = 32'h018f_fffd;
    localparam logic [31:0] FLAGS_RESET    = 32'h0000_0000;
    localparam logic [15:0] PHASE_RESET    = 16'h0000;
    localparam logic [31:0] ALWAYS_ENABLED = 32'h0000_8000;

endpackage

// ===== eimo_seq_if.sv
// carrier between the top and the phase-order checker
// assumes rise pulses are one mclk cycle wide and synchronous to mclk

`timescale 1ns/100ps

interface eimo_seq_if;
    logic [2:0] voltRise;
    logic       orderErr;

    modport judge   (input voltRise, output orderErr);
    modport user    (output voltRise, input orderErr);
endinterface

// ===== eimo_seq_check.sv
// phase-order checker: flags a phase A rising crossing followed next by phase C
// assumes one-cycle rise pulses on mclk; b and c together after a count as correct order

`timescale 1ns/100ps

module eimo_seq_check (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // rise pulses in, error pulse out
    eimo_seq_if.judge seq
);

    typedef enum logic {ST_WAIT_A, ST_AFTER_A} eimo_seq_state_type;

    eimo_seq_state_type state_r;
    eimo_seq_state_type state_nxt;
    logic               err_r;
    logic               err_nxt;

    always_comb begin
        state_nxt = state_r;
        err_nxt   = 1'b0;
        case (state_r)
            ST_WAIT_A: begin
                if (seq.voltRise[0]) begin
                    state_nxt = ST_AFTER_A;
                end
            end
            ST_AFTER_A: begin
                // the crossing that follows a decides the order
                if (seq.voltRise[1]) begin
                    state_nxt = ST_WAIT_A;
                end else if (seq.voltRise[2]) begin
                    err_nxt   = 1'b1;
                    state_nxt = ST_WAIT_A;
                end
            end
            default: state_nxt = ST_WAIT_A;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_WAIT_A;
            err_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            err_r   <= err_nxt;
        end
    end

    assign seq.orderErr = err_r;

    sequence aThenC;
        (state_r == ST_AFTER_A) && seq.voltRise[2] && !seq.voltRise[1];
    endsequence

    AST_ORDER_ERR: assert property (@(posedge mclk) disable iff (!rst_n)
        aThenC |=> seq.orderErr)
        else $error("phase order error not flagged after a then c");

    AST_ORDER_OK: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_r == ST_AFTER_A) && seq.voltRise[1] |=> !seq.orderErr)
        else $error("phase order error raised after a then b");

endmodule

// ===== eimo_top.sv
// event interrupt mask block: mask register, event flags, phase sources, irq
// assumes event inputs are synchronous to mclk; apb master per amba apb with psel/penable
//
// Function
// - mask bit 0 enables irq when a phase enters active/reactive no-load
// - mask bit 2 enables irq when a phase enters apparent no-load
// - mask bit 1 reserved, writes ignored, resets to zero
// - mask bits 3-5 enable irq on missed voltage crossing, phases a, b, c
// - mask bits 6-8 enable irq on missed current crossing, phases a, b, c
// - mask bits 9-11 enable irq on detected voltage crossing, phases a, b, c
// - mask bits 12-14 enable irq on detected current crossing, phases a, b, c
// - reset-done irq always enabled; mask bit 15 writable but without effect
// - mask bit 16 enables dip irq; phases shown in phase source bits 14-12
// - mask bit 17 enables overcurrent irq; phases shown in bits 5-3
// - mask bit 18 enables overvoltage irq; phases shown in bits 11-9
// - mask bit 19 enables irq when a rising a crossing is followed by c
// - mask bit 23 enables irq when current peak period ends
// - mask bit 24 enables irq when voltage peak period ends
// - mask bits 20-22 and 25-31 reserved, writes ignored, reset to zero
// - phase source bits 3-5 mark phase currents causing overcurrent flag bit 17
// - phase source bits 12-14 mark phase voltages causing dip flag bit 16
//
// The APB interface to the registers was decided locally.

`timescale 1ns/100ps

module eimo_top #(
    parameter int PADDR_W = 18
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // no-load levels per phase
    input  wire logic [2:0]         noloadActRe,
    input  wire logic [2:0]         noloadApparent,
    // zero-crossing pulses per phase
    input  wire logic [2:0]         voltCrossMiss,
    input  wire logic [2:0]         currCrossMiss,
    input  wire logic [2:0]         voltCross,
    input  wire logic [2:0]         currCross,
    input  wire logic [2:0]         voltRise,
    // power-quality pulses per phase
    input  wire logic [2:0]         dipPhase,
    input  wire logic [2:0]         highCurPhase,
    input  wire logic [2:0]         highVoltPhase,
    // peak detection period ends
    input  wire logic               currPeakEnd,
    input  wire logic               voltPeakEnd,
    // interrupt request
    output logic                    irq_n
);

    // the register indices need eighteen byte-address bits
    if (PADDR_W < 18) begin
        $error("PADDR_W too small for the register map");
    end

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic hitIdx(input logic [PADDR_W-1:0] a, input logic [15:0] idx);
        hitIdx = (a == PADDR_W'({idx, 2'b00}));
    endfunction

    function automatic logic [31:0] placeThree(input logic [2:0] v, input int pos);
        placeThree = 32'(v) << pos;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] mask_r;
    logic [31:0] mask_nxt;
    logic [31:0] flags_r;
    logic [31:0] flags_nxt;
    logic [15:0] phase_r;
    logic [15:0] phase_nxt;
    logic [2:0]  noloadActRe_r;
    logic [2:0]  noloadApparent_r;
    logic        started_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        slvErr_r;
    logic        slvErr_nxt;
    logic        irqN_r;
    logic        irqN_nxt;

    logic [31:0] setVec;
    logic [31:0] clrVec;
    logic [15:0] phaseSet;
    logic [15:0] phaseClr;
    logic [31:0] enabled;
    logic        setupPh;
    logic        accessPh;
    logic        hitMask;
    logic        hitPhase;
    logic        hitFlags;

    eimo_seq_if seqIf ();

    assign seqIf.voltRise = voltRise;

    eimo_seq_check uSeq (
        .mclk  (mclk),
        .rst_n (rst_n),
        .seq   (seqIf.judge)
    );

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign setupPh  = psel && !penable;
    assign accessPh = psel && penable;
    assign hitMask  = hitIdx(paddr, eimo_pkg::IDX_EVENT_MASK);
    assign hitPhase = hitIdx(paddr, eimo_pkg::IDX_PHASE_SOURCE);
    assign hitFlags = hitIdx(paddr, eimo_pkg::IDX_MAIN_FLAGS);

    // read data and error are prepared during setup, so the access phase never waits
    always_comb begin
        rdata_nxt  = rdata_r;
        slvErr_nxt = slvErr_r;
        if (setupPh) begin
            slvErr_nxt = 1'b0;
            if (hitMask) begin
                rdata_nxt = mask_r;
            end else if (hitPhase) begin
                rdata_nxt = {16'h0000, phase_r};
            end else if (hitFlags) begin
                rdata_nxt = flags_r;
            end else begin
                rdata_nxt  = 32'h0000_0000;
                slvErr_nxt = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // event collection
    // ----------------------------------------------------------------
    always_comb begin
        setVec = 32'h0000_0000;
        setVec[eimo_pkg::BIT_NOLOAD_ACTRE] = |(noloadActRe & ~noloadActRe_r);
        setVec[eimo_pkg::BIT_NOLOAD_APPAR] = |(noloadApparent & ~noloadApparent_r);
        setVec = setVec | placeThree(voltCrossMiss, eimo_pkg::BIT_VOLT_MISS);
        setVec = setVec | placeThree(currCrossMiss, eimo_pkg::BIT_CURR_MISS);
        setVec = setVec | placeThree(voltCross, eimo_pkg::BIT_VOLT_CROSS);
        setVec = setVec | placeThree(currCross, eimo_pkg::BIT_CURR_CROSS);
        setVec[eimo_pkg::BIT_RESET_DONE]  = !started_r;
        setVec[eimo_pkg::BIT_DIP]         = |dipPhase;
        setVec[eimo_pkg::BIT_HIGH_CURR]   = |highCurPhase;
        setVec[eimo_pkg::BIT_HIGH_VOLT]   = |highVoltPhase;
        setVec[eimo_pkg::BIT_PHASE_ORDER] = seqIf.orderErr;
        setVec[eimo_pkg::BIT_CURR_PEAK]   = currPeakEnd;
        setVec[eimo_pkg::BIT_VOLT_PEAK]   = voltPeakEnd;
    end

    assign clrVec = (accessPh && pwrite && hitFlags) ? pwdata : 32'h0000_0000;

    // phase sources follow their main flag: cleared together, set wins
    always_comb begin
        phaseSet = 16'(placeThree(highCurPhase, eimo_pkg::PH_HIGH_CURR))
                 | 16'(placeThree(highVoltPhase, eimo_pkg::PH_HIGH_VOLT))
                 | 16'(placeThree(dipPhase, eimo_pkg::PH_DIP));
        phaseClr = 16'h0000;
        phaseClr = phaseClr | 16'(placeThree({3{clrVec[eimo_pkg::BIT_HIGH_CURR]}},
                                             eimo_pkg::PH_HIGH_CURR));
        phaseClr = phaseClr | 16'(placeThree({3{clrVec[eimo_pkg::BIT_HIGH_VOLT]}},
                                             eimo_pkg::PH_HIGH_VOLT));
        phaseClr = phaseClr | 16'(placeThree({3{clrVec[eimo_pkg::BIT_DIP]}},
                                             eimo_pkg::PH_DIP));
        phase_nxt = (phase_r & ~phaseClr) | phaseSet;
    end

    // ----------------------------------------------------------------
    // mask, flags, irq
    // ----------------------------------------------------------------
    // reserved mask bits are never stored, so they read zero whatever is written
    always_comb begin
        mask_nxt = mask_r;
        if (accessPh && pwrite && hitMask) begin
            mask_nxt = pwdata & eimo_pkg::MASK_WRITABLE;
        end
    end

    // a flag raised in the cycle it is cleared survives; the mask is not consulted
    assign flags_nxt = ((flags_r & ~clrVec) | setVec) & eimo_pkg::MASK_WRITABLE;

    // mask bit 15 is stored but the reset-done flag is enabled regardless
    assign enabled  = (mask_r & ~eimo_pkg::ALWAYS_ENABLED) | eimo_pkg::ALWAYS_ENABLED;
    assign irqN_nxt = !(|(flags_r & enabled));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r           <= eimo_pkg::MASK_RESET;
            flags_r          <= eimo_pkg::FLAGS_RESET;
            phase_r          <= eimo_pkg::PHASE_RESET;
            noloadActRe_r    <= 3'h0;
            noloadApparent_r <= 3'h0;
            started_r        <= 1'b0;
            rdata_r          <= 32'h0000_0000;
            slvErr_r         <= 1'b0;
            irqN_r           <= 1'b1;
        end else begin
            mask_r           <= mask_nxt;
            flags_r          <= flags_nxt;
            phase_r          <= phase_nxt;
            noloadActRe_r    <= noloadActRe;
            noloadApparent_r <= noloadApparent;
            started_r        <= 1'b1;
            rdata_r          <= rdata_nxt;
            slvErr_r         <= slvErr_nxt;
            irqN_r           <= irqN_nxt;
        end
    end

    assign pready  = accessPh;
    assign prdata  = rdata_r;
    assign pslverr = slvErr_r;
    assign irq_n   = irqN_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence maskWrite;
        accessPh && pwrite && hitMask;
    endsequence

    AST_NOLOAD_ACTRE: assert property (@(posedge mclk) disable iff (!rst_n)
        mask_r[0] && |(noloadActRe & ~noloadActRe_r) |=> ##1 !irq_n)
        else $error("active/reactive no-load entry did not raise irq");

    AST_NOLOAD_APPAR: assert property (@(posedge mclk) disable iff (!rst_n)
        mask_r[2] && |(noloadApparent & ~noloadApparent_r) |=> ##1 !irq_n)
        else $error("apparent no-load entry did not raise irq");

    AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
        maskWrite |=> (mask_r & ~eimo_pkg::MASK_WRITABLE) == 32'h0000_0000)
        else $error("reserved mask bits stored a written one");

    AST_VOLT_MISS: assert property (@(posedge mclk) disable iff (!rst_n)
        voltCrossMiss[1] |=> flags_r[eimo_pkg::BIT_VOLT_MISS + 1])
        else $error("missed voltage crossing b not flagged");

    AST_CURR_MISS: assert property (@(posedge mclk) disable iff (!rst_n)
        currCrossMiss[2] |=> flags_r[eimo_pkg::BIT_CURR_MISS + 2])
        else $error("missed current crossing c not flagged");

    AST_VOLT_CROSS: assert property (@(posedge mclk) disable iff (!rst_n)
        voltCross[0] |=> flags_r[eimo_pkg::BIT_VOLT_CROSS])
        else $error("detected voltage crossing a not flagged");

    AST_CURR_CROSS: assert property (@(posedge mclk) disable iff (!rst_n)
        currCross[2] |=> flags_r[eimo_pkg::BIT_CURR_CROSS + 2])
        else $error("detected current crossing c not flagged");

    AST_RESET_DONE: assert property (@(posedge mclk) disable iff (!rst_n)
        flags_r[eimo_pkg::BIT_RESET_DONE] |=> !irq_n)
        else $error("reset-done flag did not raise irq");

    AST_DIP_PHASE: assert property (@(posedge mclk) disable iff (!rst_n)
        dipPhase[2] |=> phase_r[14] && flags_r[eimo_pkg::BIT_DIP])
        else $error("dip phase c not recorded");

    AST_HIGH_CURR_PHASE: assert property (@(posedge mclk) disable iff (!rst_n)
        highCurPhase[0] |=> phase_r[3] && flags_r[eimo_pkg::BIT_HIGH_CURR])
        else $error("overcurrent phase a not recorded");

    AST_HIGH_VOLT_PHASE: assert property (@(posedge mclk) disable iff (!rst_n)
        highVoltPhase[1] |=> phase_r[eimo_pkg::PH_HIGH_VOLT + 1]
                             && flags_r[eimo_pkg::BIT_HIGH_VOLT])
        else $error("overvoltage phase b not recorded");

    AST_PHASE_RESERVED: assert property (@(posedge mclk) disable iff (!rst_n)
        (phase_r & 16'h81c7) == 16'h0000)
        else $error("reserved phase source bit set");

    AST_ORDER_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
        seqIf.orderErr |=> flags_r[eimo_pkg::BIT_PHASE_ORDER])
        else $error("phase order error not flagged");

    AST_PEAK: assert property (@(posedge mclk) disable iff (!rst_n)
        voltPeakEnd && mask_r[24] |=> ##1 !irq_n)
        else $error("voltage peak period end did not raise irq");

    AST_CURR_PEAK: assert property (@(posedge mclk) disable iff (!rst_n)
        currPeakEnd && mask_r[eimo_pkg::BIT_CURR_PEAK] |=> ##1 !irq_n)
        else $error("current peak period end did not raise irq");

    AST_IRQ_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
        (flags_r & enabled) == 32'h0000_0000 |=> irq_n)
        else $error("irq held with no enabled flag pending");

    AST_MASKED_SILENT: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(irq_n) |-> $past(|(flags_r & enabled)))
        else $error("irq raised without an enabled flag");

endmodule

// ===== eimo_top_bench.sv
// self-checking bench of the event interrupt mask block, apb tasks plus event pulses
// assumes zero-wait apb slave, flags in the main flag register cleared by writing one

`timescale 1ns/100ps

module eimo_top_bench;
    // ----------------------------------------------------------------
    // addresses and event table
    // ----------------------------------------------------------------
    localparam logic [17:0] A_MASK = {eimo_pkg::IDX_EVENT_MASK, 2'b00};
    localparam logic [17:0] A_PH   = {eimo_pkg::IDX_PHASE_SOURCE, 2'b00};
    localparam logic [17:0] A_FLAG = {eimo_pkg::IDX_MAIN_FLAGS, 2'b00};
    localparam logic [17:0] A_NONE = 18'h00010;
    localparam int          BASE [11] = '{0, 2, 3, 6, 9, 12, 16, 17, 18, 23, 24};

    logic        mclk = 1'b0;
    logic        rst_n, psel, penable, pwrite, pready, pslverr, er, irq_n;
    logic        currPeakEnd, voltPeakEnd;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd, expF, expP;
    logic [2:0]  noloadActRe, noloadApparent, voltCrossMiss, currCrossMiss;
    logic [2:0]  voltCross, currCross, voltRise, dipPhase, highCurPhase, highVoltPhase;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          bitNo, phBit;

    always #5 mclk = ~mclk;

    eimo_top #(.PADDR_W(18)) DUT (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .noloadActRe(noloadActRe), .noloadApparent(noloadApparent),
        .voltCrossMiss(voltCrossMiss), .currCrossMiss(currCrossMiss),
        .voltCross(voltCross), .currCross(currCross), .voltRise(voltRise),
        .dipPhase(dipPhase), .highCurPhase(highCurPhase), .highVoltPhase(highVoltPhase),
        .currPeakEnd(currPeakEnd), .voltPeakEnd(voltPeakEnd), .irq_n(irq_n)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    // one apb transfer; the wait on pready is bounded so a dead slave still ends the run
    task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rdchk(input logic [17:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0, er}, 32'h0000_0000);
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // no-load inputs are levels; dropping them next cycle is no event, so one shape fits all
    task automatic ev(input int k, input int p);
        @(posedge mclk);
        case (k)
            0: noloadActRe[p] <= 1'b1;
            1: noloadApparent[p] <= 1'b1;
            2: voltCrossMiss[p] <= 1'b1;
            3: currCrossMiss[p] <= 1'b1;
            4: voltCross[p] <= 1'b1;
            5: currCross[p] <= 1'b1;
            6: dipPhase[p] <= 1'b1;
            7: highCurPhase[p] <= 1'b1;
            8: highVoltPhase[p] <= 1'b1;
            9: currPeakEnd <= 1'b1;
            default: voltPeakEnd <= 1'b1;
        endcase
        @(posedge mclk);
        {noloadActRe, noloadApparent, voltCrossMiss, currCrossMiss} <= 12'h000;
        {voltCross, currCross, dipPhase, highCurPhase, highVoltPhase} <= 15'h0000;
        {currPeakEnd, voltPeakEnd} <= 2'b00;
    endtask

    task automatic rise(input logic [2:0] v);
        @(posedge mclk);
        voltRise <= v;
        @(posedge mclk);
        voltRise <= 3'b000;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {noloadActRe, noloadApparent, voltCrossMiss, currCrossMiss} = '0;
        {voltCross, currCross, voltRise, dipPhase, highCurPhase, highVoltPhase} = '0;
        {currPeakEnd, voltPeakEnd} = 2'b00;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        settle();
        rdchk(A_MASK, 32'h0000_0000);
        rdchk(A_FLAG, 32'h0000_8000);
        chk({31'h0, irq_n}, 32'h0000_0000);
        wr(A_FLAG, 32'h0000_8000);
        settle();
        chk({31'h0, irq_n}, 32'h0000_0001);
        wr(A_MASK, 32'hffff_ffff);
        rdchk(A_MASK, 32'h018f_fffd);
        settle();
        chk({31'h0, irq_n}, 32'h0000_0001);
        wr(A_MASK, 32'h0000_0000);
        apb(A_NONE, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        wr(A_PH, 32'h0000_ffff);
        rdchk(A_PH, 32'h0000_0000);
        for (int k = 0; k < 11; k++) begin
            for (int p = 0; p < 3; p++) begin
                if (p == 0 || (k >= 2 && k <= 8)) begin
                    bitNo = BASE[k] + ((k >= 2 && k <= 5) ? p : 0);
                    phBit = (k == 6) ? 12 : (k == 7) ? 3 : (k == 8) ? 9 : -1;
                    expF  = 32'h1 << bitNo;
                    expP  = (phBit < 0) ? 32'h0 : (32'h1 << (phBit + p));
                    ev(k, p);
                    rdchk(A_FLAG, expF);
                    rdchk(A_PH, expP);
                    chk({31'h0, irq_n}, 32'h0000_0001);
                    wr(A_MASK, expF);
                    settle();
                    chk({31'h0, irq_n}, 32'h0000_0000);
                    wr(A_FLAG, expF);
                    settle();
                    chk({31'h0, irq_n}, 32'h0000_0001);
                    rdchk(A_PH, 32'h0000_0000);
                    rdchk(A_FLAG, 32'h0000_0000);
                    // the same event again, now with its mask bit already set
                    ev(k, p);
                    settle();
                    chk({31'h0, irq_n}, 32'h0000_0000);
                    wr(A_FLAG, expF);
                    wr(A_MASK, 32'h0000_0000);
                end
            end
        end
        // phase order: a-b-c and a-(b,c) are correct, a-c is the error
        wr(A_MASK, 32'h0008_0000);
        rise(3'b001);
        rise(3'b010);
        rise(3'b100);
        rise(3'b001);
        rise(3'b110);
        settle();
        rdchk(A_FLAG, 32'h0000_0000);
        chk({31'h0, irq_n}, 32'h0000_0001);
        rise(3'b001);
        rise(3'b100);
        settle();
        rdchk(A_FLAG, 32'h0008_0000);
        chk({31'h0, irq_n}, 32'h0000_0000);
        wr(A_FLAG, 32'h0008_0000);
        settle();
        chk({31'h0, irq_n}, 32'h0000_0001);
        // reset in mid-run: mask returns to zero, reset-done is flagged again
        wr(A_MASK, 32'h0100_0000);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        settle();
        rdchk(A_MASK, 32'h0000_0000);
        rdchk(A_FLAG, 32'h0000_8000);
        chk({31'h0, irq_n}, 32'h0000_0000);
        stop_test();
    end
endmodule
